// *** spllc_pkg.sv ***
package spllc_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // serial word layout, last bit shifted in sits at bit 0
   localparam int WORD_W = 20;
   localparam int REF_W = 14;
   localparam int PROG_W = 11;
   localparam int SWAL_W = 7;
   localparam int DEST_POS = 0;
   localparam int REF_LSB = 1;
   localparam int CS_POS = 15;
   localparam int LDS_POS = 16;
   localparam int FC_POS = 17;
   localparam int SWAL_LSB = 1;
   localparam int PROG_LSB = 8;
   localparam int SW_POS = 19;

   ////////////////////////////////////////////////////////////////////////////
   // prescaler moduli
   localparam logic [7:0] PRESC_MOD_SMALL = 8'h40;
   localparam logic [7:0] PRESC_MOD_LARGE = 8'h80;

   ////////////////////////////////////////////////////////////////////////////
   // latch contents after reset
   localparam logic [REF_W-1:0] RST_REF_DIV = 14'h000a;
   localparam logic [PROG_W-1:0] RST_PROG_DIV = 11'h00a;
   localparam logic [SWAL_W-1:0] RST_SWAL_DIV = 7'h00;
   localparam logic RST_MOD_SEL = 1'b1;
   localparam logic RST_CUR_SEL = 1'b0;
   localparam logic RST_MON_SEL = 1'b0;
   localparam logic RST_POL_SEL = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // apb map
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_REF = 12'h004;
   localparam logic [ADDR_W-1:0] ADDR_MAIN = 12'h008;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h00c;
   localparam logic [7:0] RST_LOCK_TOL = 8'h04;
   localparam logic [7:0] RST_ERR_LIMIT = 8'h08;
   localparam logic [1:0] WAKE_CMP = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // synchronised pin slots
   localparam int NUM_PINS = 7;
   localparam int PIN_SCLK = 0;
   localparam int PIN_SDATA = 1;
   localparam int PIN_LOAD = 2;
   localparam int PIN_OSC = 3;
   localparam int PIN_VCO = 4;
   localparam int PIN_PUMPEN = 5;
   localparam int PIN_PSN = 6;
   localparam logic [NUM_PINS-1:0] PIN_RST_LVL = 7'h00;

   typedef enum logic [2:0]
   {
      PWR_SAVE = 3'b001,
      PWR_WAKE = 3'b010,
      PWR_RUN = 3'b100
   } spllc_pwr_e;
endpackage

// *** spllc_pin_sync.sv ***
module spllc_pin_sync
   #(parameter int WIDTH = 1,
     parameter logic [WIDTH-1:0] RST_LVL = '0)
   (
   input wire logic clk, // system clock
   input wire logic rst_n, // sync reset, active low
   input wire logic [WIDTH-1:0] pinIn, // raw asynchronous pins
   output logic [WIDTH-1:0] level, // filtered level
   output logic [WIDTH-1:0] rise // one-cycle pulse on accepted rise
   );

   logic [WIDTH-1:0] s1_ff;
   logic [WIDTH-1:0] s2_ff;
   logic [WIDTH-1:0] s3_ff;
   logic [WIDTH-1:0] lvl_ff;
   logic [WIDTH-1:0] rise_ff;

   ////////////////////////////////////////////////////////////////////////////
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         // three stages; s1 feeds only s2 to keep metastability contained
         always_ff @(posedge clk)
         begin
            if (!rst_n)
            begin
               s1_ff[i] <= RST_LVL[i];
               s2_ff[i] <= RST_LVL[i];
               s3_ff[i] <= RST_LVL[i];
               lvl_ff[i] <= RST_LVL[i];
               rise_ff[i] <= 1'b0;
            end
            else
            begin
               s1_ff[i] <= pinIn[i];
               s2_ff[i] <= s1_ff[i];
               s3_ff[i] <= s2_ff[i];
               // accept a change only once stages two and three agree
               if (s2_ff[i] == s3_ff[i])
                  lvl_ff[i] <= s3_ff[i];
               rise_ff[i] <= (s2_ff[i] == s3_ff[i]) && s3_ff[i] && !lvl_ff[i];
            end
         end
      end
   endgenerate

   assign level = lvl_ff;
   assign rise = rise_ff;
endmodule // spllc_pin_sync

// *** spllc_top.sv ***
// Behaviour
// R1: vco equals (M*N+A)*fosc/R, A<N
// R2: program counter 11 bits, ratios 3..2047
// R3: swallow counter 7 bits, values 0..127
// R4: reference counter 14 bits, ratios 3..16383
// R5: modulus select high 64/65, low 128/129
// R6: shift data bit on serial clock rise
// R7: load strobe rise latches word to target
// R8: destination high reference, low main divider
// R9: host keeps strobe low while shifting
// R10: host never programs ratios below three
// R11: current select high large, low small
// R12: monitor select high frequency, low lock
// R13: polarity high output table for comparator
// R14: polarity low inverts pump and phase outputs
// R15: monitor shows fr if polarity high else fp
// R16: pump enable low forces pump high impedance
// R17: power save low tristates pump, idles device
// R18: lock indicator high during power save
// R19: limit error magnitude when leaving power save
// R20: host holds power save low after power-up
// R21: fixed serial word format shared both ends
//
// Local design decisions: the APB interface to the registers and the register offsets.
module spllc_top
   import spllc_pkg::*;
   (
   input wire logic clk, // 100 MHz system clock
   input wire logic rst_n, // sync reset, active low
   input wire logic [spllc_pkg::ADDR_W-1:0] paddr, // apb address
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic serClk, // serial shift clock pin
   input wire logic serData, // serial data pin
   input wire logic loadStrobe, // word load strobe pin
   input wire logic oscIn, // reference oscillator
   input wire logic vcoIn, // vco clock into prescaler
   input wire logic pumpOutputEnable, // pump output enable pin
   input wire logic powerSave_n, // power save pin, active low
   output logic pumpOut, // charge pump drive level
   output logic pumpOe_n, // pump driving when low
   output logic phaseRefOut, // reference phase output
   output logic phaseCmpOut, // open-drain phase output level
   output logic phaseCmpOe_n, // open-drain phase pulling when low
   output logic lockOrMonitorPin, // lock or monitor output
   output logic pumpCurrentHigh // large pump current selected
   );
   import spllc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [NUM_PINS-1:0] pinRaw;
   logic [NUM_PINS-1:0] pinLvl;
   logic [NUM_PINS-1:0] pinRise;

   assign pinRaw = {powerSave_n, pumpOutputEnable, vcoIn, oscIn, loadStrobe, serData, serClk};

   spllc_pin_sync #(.WIDTH(NUM_PINS), .RST_LVL(PIN_RST_LVL)) u_sync
   (
      .clk(clk),
      .rst_n(rst_n),
      .pinIn(pinRaw),
      .level(pinLvl),
      .rise(pinRise)
   );

   ////////////////////////////////////////////////////////////////////////////
   // serial shift register and latches

   logic [WORD_W-1:0] shift_ff;
   logic [REF_W-1:0] refDiv_ff;
   logic curSel_ff;
   logic monSel_ff;
   logic polSel_ff;
   logic [PROG_W-1:0] progDiv_ff;
   logic [SWAL_W-1:0] swalDiv_ff;
   logic modSel_ff;

   // shift in on each accepted serial clock rise
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         shift_ff <= '0;
      else if (pinRise[PIN_SCLK])
         shift_ff <= {shift_ff[WORD_W-2:0], pinLvl[PIN_SDATA]}; // R6
   end

   // reference latch, chosen by destination bit high
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         refDiv_ff <= RST_REF_DIV;
         curSel_ff <= RST_CUR_SEL;
         monSel_ff <= RST_MON_SEL;
         polSel_ff <= RST_POL_SEL;
      end
      else if (pinRise[PIN_LOAD] && shift_ff[DEST_POS]) // R7 R8 R21
      begin
         refDiv_ff <= shift_ff[REF_LSB +: REF_W];
         curSel_ff <= shift_ff[CS_POS];
         monSel_ff <= shift_ff[LDS_POS];
         polSel_ff <= shift_ff[FC_POS];
      end
   end

   // main latch, chosen by destination bit low
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         progDiv_ff <= RST_PROG_DIV;
         swalDiv_ff <= RST_SWAL_DIV;
         modSel_ff <= RST_MOD_SEL;
      end
      else if (pinRise[PIN_LOAD] && !shift_ff[DEST_POS]) // R7 R8 R21
      begin
         progDiv_ff <= shift_ff[PROG_LSB +: PROG_W];
         swalDiv_ff <= shift_ff[SWAL_LSB +: SWAL_W];
         modSel_ff <= shift_ff[SW_POS];
      end
   end

   assign pumpCurrentHigh = curSel_ff; // R11

   ////////////////////////////////////////////////////////////////////////////
   // power mode

   spllc_pwr_e pwr_ff;
   spllc_pwr_e nxt_pwr;
   logic [1:0] wakeCnt_ff;
   logic psActive;
   logic frPulse_ff;
   logic fpPulse_ff;

   assign psActive = (pwr_ff == PWR_SAVE);

   // wake phase lasts a fixed number of comparisons
   always_comb
   begin
      nxt_pwr = pwr_ff;
      case (pwr_ff)
         PWR_SAVE:
            if (pinLvl[PIN_PSN])
               nxt_pwr = PWR_WAKE; // R17
         PWR_WAKE:
            if (!pinLvl[PIN_PSN])
               nxt_pwr = PWR_SAVE;
            else if (frPulse_ff && wakeCnt_ff == WAKE_CMP - 2'h1)
               nxt_pwr = PWR_RUN;
         PWR_RUN:
            if (!pinLvl[PIN_PSN])
               nxt_pwr = PWR_SAVE; // R17
         default:
            nxt_pwr = PWR_SAVE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         pwr_ff <= PWR_SAVE;
      else
         pwr_ff <= nxt_pwr;
   end

   // comparisons seen during the wake phase, cleared in every other mode
   always_ff @(posedge clk)
   begin
      if (!rst_n || pwr_ff != PWR_WAKE)
         wakeCnt_ff <= '0;
      else if (frPulse_ff)
         wakeCnt_ff <= wakeCnt_ff + 2'h1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // reference divider

   logic [REF_W-1:0] refLeft_ff;

   // held at full count in power save so both dividers restart aligned
   always_ff @(posedge clk)
   begin
      if (!rst_n || psActive)
      begin
         refLeft_ff <= refDiv_ff; // R19
         frPulse_ff <= 1'b0;
      end
      else
      begin
         frPulse_ff <= 1'b0;
         if (pinRise[PIN_OSC])
         begin
            // ratios below three are the host's to avoid; lower ones still wrap
            if (refLeft_ff <= REF_W'(1)) // R4 R10
            begin
               refLeft_ff <= refDiv_ff;
               frPulse_ff <= 1'b1;
            end
            else
               refLeft_ff <= refLeft_ff - REF_W'(1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // dual modulus prescaler with swallow and program counters

   logic [7:0] presCnt_ff;
   logic presOut;
   logic [7:0] curMod;
   logic [SWAL_W-1:0] swalLeft_ff;
   logic [PROG_W-1:0] progLeft_ff;

   // modulus M, plus one while swallow counter is non-zero
   assign curMod = (modSel_ff ? PRESC_MOD_SMALL : PRESC_MOD_LARGE)
                   + ((swalLeft_ff != '0) ? 8'h01 : 8'h00); // R5
   assign presOut = pinRise[PIN_VCO] && (presCnt_ff == curMod - 8'h01);

   always_ff @(posedge clk)
   begin
      if (!rst_n || psActive)
         presCnt_ff <= '0;
      else if (presOut)
         presCnt_ff <= '0;
      else if (pinRise[PIN_VCO])
         presCnt_ff <= presCnt_ff + 8'h01;
   end

   // A cycles of M+1 then N-A of M gives M*N+A per output
   always_ff @(posedge clk)
   begin
      if (!rst_n || psActive)
      begin
         progLeft_ff <= progDiv_ff;
         swalLeft_ff <= swalDiv_ff;
         fpPulse_ff <= 1'b0;
      end
      else
      begin
         fpPulse_ff <= 1'b0;
         if (presOut)
         begin
            if (progLeft_ff <= PROG_W'(1)) // R1 R2 R10
            begin
               progLeft_ff <= progDiv_ff;
               swalLeft_ff <= swalDiv_ff; // R3
               fpPulse_ff <= 1'b1;
            end
            else
            begin
               progLeft_ff <= progLeft_ff - PROG_W'(1);
               if (swalLeft_ff != '0)
                  swalLeft_ff <= swalLeft_ff - SWAL_W'(1); // R1
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // phase frequency detector

   logic upFf;
   logic dnFf;
   logic nxtUp;
   logic nxtDn;

   // up means reference leads, down means divided vco leads
   always_comb
   begin
      nxtUp = upFf | frPulse_ff;
      nxtDn = dnFf | fpPulse_ff;
      if (nxtUp && nxtDn)
      begin
         nxtUp = 1'b0;
         nxtDn = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n || psActive)
      begin
         upFf <= 1'b0;
         dnFf <= 1'b0;
      end
      else
      begin
         upFf <= nxtUp;
         dnFf <= nxtDn;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // error width measurement, lock detect and wake limiting

   logic [7:0] errWidth_ff;
   logic lock_ff;
   logic [7:0] lockTol_ff;
   logic [7:0] errLimit_ff;
   logic limitHit;

   // saturating count of active pump cycles within one comparison
   always_ff @(posedge clk)
   begin
      if (!rst_n || psActive || frPulse_ff)
         errWidth_ff <= '0;
      else if ((upFf || dnFf) && errWidth_ff != 8'hff)
         errWidth_ff <= errWidth_ff + 8'h01;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         lock_ff <= 1'b0;
      else if (psActive)
         lock_ff <= 1'b0;
      else if (frPulse_ff)
         lock_ff <= (errWidth_ff <= lockTol_ff);
   end

   // during wake the pump is cut once the error reaches the limit
   assign limitHit = (pwr_ff == PWR_WAKE) && (errWidth_ff >= errLimit_ff); // R19

   ////////////////////////////////////////////////////////////////////////////
   // output stage

   logic lockInd;
   logic pumpDrive;

   assign lockInd = psActive | lock_ff; // R18
   assign pumpDrive = (upFf || dnFf) && pinLvl[PIN_PUMPEN] && !psActive && !limitHit; // R16 R17

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pumpOut <= 1'b0;
         pumpOe_n <= 1'b1;
         phaseRefOut <= 1'b0;
         phaseCmpOe_n <= 1'b1;
         lockOrMonitorPin <= 1'b0;
      end
      else
      begin
         pumpOut <= upFf ? polSel_ff : !polSel_ff; // R13 R14
         pumpOe_n <= !pumpDrive; // R16 R17
         phaseRefOut <= polSel_ff ? dnFf : upFf; // R13 R14
         phaseCmpOe_n <= !(polSel_ff ? upFf : dnFf); // R13 R14
         // the monitor shows one-cycle pulses at the divided rate
         if (monSel_ff) // R12
            lockOrMonitorPin <= polSel_ff ? frPulse_ff : fpPulse_ff; // R15
         else
            lockOrMonitorPin <= lockInd; // R12 R18
      end
   end

   assign phaseCmpOut = 1'b0; // open-drain only ever pulls low

   ////////////////////////////////////////////////////////////////////////////
   // apb slave, no wait state; read data comes from a flop loaded in setup

   logic setupPh;
   logic accessPh;
   logic mapped;
   logic [31:0] rdSel;
   logic [31:0] prdata_ff;
   logic err_ff;

   assign setupPh = psel && !penable;
   assign accessPh = psel && penable;
   assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_REF)
                   || (paddr == ADDR_MAIN) || (paddr == ADDR_STATUS);

   always_comb
   begin
      rdSel = '0;
      case (paddr)
         ADDR_CTRL:
            rdSel = {16'h0000, errLimit_ff, lockTol_ff};
         ADDR_REF:
            rdSel = {14'h0000, polSel_ff, monSel_ff, curSel_ff, 1'b0, refDiv_ff};
         ADDR_MAIN:
            rdSel = {12'h000, modSel_ff, progDiv_ff, 1'b0, swalDiv_ff};
         ADDR_STATUS:
            rdSel = {24'h000000, pwr_ff == PWR_WAKE, pinLvl[PIN_PUMPEN], upFf, dnFf,
                     pinLvl[PIN_PSN], psActive, lock_ff, lockInd};
         default:
            rdSel = '0;
      endcase
   end

   // read data and error captured in the setup cycle
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         prdata_ff <= '0;
         err_ff <= 1'b0;
      end
      else if (setupPh)
      begin
         prdata_ff <= pwrite ? 32'h00000000 : rdSel;
         err_ff <= !mapped;
      end
   end

   // only the control word is writable; other mapped writes are dropped
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         lockTol_ff <= RST_LOCK_TOL;
         errLimit_ff <= RST_ERR_LIMIT;
      end
      else if (accessPh && pwrite && paddr == ADDR_CTRL)
      begin
         lockTol_ff <= pwdata[7:0];
         errLimit_ff <= pwdata[15:8];
      end
   end

   assign pready = accessPh;
   assign prdata = prdata_ff;
   assign pslverr = accessPh && err_ff;
endmodule // spllc_top

// *** spllc_top_asserts.sv ***
module spllc_top_asserts
   import spllc_pkg::*;
   (
   input wire logic clk, // clock
   input wire logic rst_n, // reset
   input wire logic [spllc_pkg::ADDR_W-1:0] paddr, // address
   input wire logic psel, // select
   input wire logic penable, // enable
   input wire logic pwrite, // direction
   input wire logic [31:0] prdata, // read data
   input wire logic pready, // ready
   input wire logic pslverr, // error
   input wire logic pumpOutputEnable, // pump enable pin
   input wire logic powerSave_n, // power save pin
   input wire logic pumpOut, // pump level
   input wire logic pumpOe_n, // pump drives when low
   input wire logic phaseRefOut, // ref phase
   input wire logic phaseCmpOut, // open-drain level
   input wire logic phaseCmpOe_n // open-drain enable
   );
   timeunit 1ns;
   timeprecision 1ps;
   logic unmapped;
   ////////////////////////////////////////////////////////////////////////////
   // only the four low words are mapped
   assign unmapped = !(paddr inside {ADDR_CTRL, ADDR_REF, ADDR_MAIN, ADDR_STATUS});
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////
   // bus answers
   AST_READY: assert property (psel && penable |-> pready)
      else $error("no ready in access");
   AST_IDLE: assert property (!psel |-> !pready && !pslverr)
      else $error("answer without select");
   AST_UNMAPPED: assert property (psel && !penable && unmapped ##1 penable |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   AST_MAPPED: assert property (psel && !penable && !unmapped ##1 penable |-> !pslverr)
      else $error("mapped access refused");
   AST_WR_DATA: assert property (psel && penable && pwrite |-> prdata == 32'h0)
      else $error("read data on write");
   ////////////////////////////////////////////////////////////////////////////
   // pump and phase outputs; six cycles cover the pin synchroniser
   AST_PUMP_EN: assert property (!pumpOutputEnable [*6] |-> pumpOe_n)
      else $error("pump drives while disabled");
   AST_PSAVE: assert property (!powerSave_n [*8] |-> pumpOe_n && phaseCmpOe_n)
      else $error("outputs active in power save");
   AST_WAKE: assert property ($rose(powerSave_n) |-> pumpOe_n [*4])
      else $error("pump jumps on wake");
   AST_PUMP_PHASE: assert property (!pumpOe_n |-> pumpOut == !phaseCmpOe_n && pumpOut != phaseRefOut)
      else $error("pump and phase disagree");
   AST_PHASE_EXCL: assert property (!phaseCmpOe_n |-> !phaseRefOut && !phaseCmpOut)
      else $error("both phase outputs active");
   cover property (!pumpOe_n && pumpOut);
   cover property (!pumpOe_n && !pumpOut);
   cover property (psel && penable && pslverr);
endmodule // spllc_top_asserts

bind spllc_top spllc_top_asserts u_asserts (.clk(clk), .rst_n(rst_n), .paddr(paddr),
   .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pumpOutputEnable(pumpOutputEnable), .powerSave_n(powerSave_n),
   .pumpOut(pumpOut), .pumpOe_n(pumpOe_n), .phaseRefOut(phaseRefOut),
   .phaseCmpOut(phaseCmpOut), .phaseCmpOe_n(phaseCmpOe_n));

// *** spllc_serial_host.sv ***
module spllc_serial_host
   (
   output logic serClk, // shift clock, still between frames
   output logic serData, // data, moves while clock low
   output logic loadStrobe // latch strobe
   );
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////////////////////
   // idle pins at time zero
   initial
   begin
      serClk = 1'b0;
      serData = 1'b0;
      loadStrobe = 1'b0;
   end
   // msb first; extra leading bits fall out, only the last 20 count
   task automatic send_word(input logic [23:0] w);
      for (int i = 23; i >= 0; i--)
      begin
         serData = w[i];
         #62.5 serClk = 1'b1;
         #62.5 serClk = 1'b0;
      end
      // stale data must never look valid after the frame
      serData = ~w[0];
      #62.5 loadStrobe = 1'b1;
      #125 loadStrobe = 1'b0;
      #62.5;
   endtask
endmodule // spllc_serial_host

// *** spllc_tb_top.sv ***
module spllc_tb_top
   import spllc_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int VCO_CLK = 6;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = '0;
   logic oscIn = 1'b0;
   logic vcoIn = 1'b0;
   logic pumpOutputEnable = 1'b1;
   logic powerSave_n = 1'b0;
   logic [1:0] oscCnt = '0;
   logic [1:0] vcoCnt = '0;
   logic [31:0] prdata;
   logic pready, pslverr, serClk, serData, loadStrobe, pumpOut, pumpOe_n;
   logic phaseRefOut, phaseCmpOut, phaseCmpOe_n, lockOrMonitorPin, pumpCurrentHigh;
   int n_mismatch = 0;
   int samples_checked = 0;
   ////////////////////////////////////////////////////////////////////////////
   spllc_top uut (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serClk(serClk), .serData(serData), .loadStrobe(loadStrobe), .oscIn(oscIn),
      .vcoIn(vcoIn), .pumpOutputEnable(pumpOutputEnable), .powerSave_n(powerSave_n),
      .pumpOut(pumpOut), .pumpOe_n(pumpOe_n), .phaseRefOut(phaseRefOut),
      .phaseCmpOut(phaseCmpOut), .phaseCmpOe_n(phaseCmpOe_n),
      .lockOrMonitorPin(lockOrMonitorPin), .pumpCurrentHigh(pumpCurrentHigh));
   spllc_serial_host host (.serClk(serClk), .serData(serData), .loadStrobe(loadStrobe));
   always #5 clk = ~clk;
   // reference period 8 clk, vco period 6 clk: slow enough for the synchroniser
   always @(posedge clk)
   begin
      oscCnt <= oscCnt + 2'h1;
      vcoCnt <= (vcoCnt == 2'h2) ? 2'h0 : vcoCnt + 2'h1;
      if (oscCnt == 2'h3)
         oscIn <= ~oscIn;
      if (vcoCnt == 2'h2)
         vcoIn <= ~vcoIn;
   end
   ////////////////////////////////////////////////////////////////////////////
   // expectations
   function automatic logic [31:0] ref_reg(input logic [13:0] r, input logic [2:0] f);
      return {14'h0, f, 1'b0, r};
   endfunction
   function automatic logic [31:0] main_reg(input logic m, input logic [10:0] n,
                                            input logic [6:0] a);
      return {12'h0, m, n, 1'b0, a};
   endfunction
   function automatic int fp_gap(input logic m, input int n, input int a);
      return ((m ? PRESC_MOD_SMALL : PRESC_MOD_LARGE) * n + a) * VCO_CLK;
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic hang(input string what);
      n_mismatch++;
      $display("unexpected %s exp done got timeout", what);
      final_report();
   endtask
   // one transfer: setup, then access until ready
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16)
         hang("apb ready");
   endtask
   // send a word, then poll the latch view until it settles
   task automatic load(input logic [23:0] w, input logic [ADDR_W-1:0] a,
                       input logic [31:0] exp);
      logic [31:0] rd;
      logic err;
      host.send_word(w);
      for (int i = 0; i < 10; i++)
      begin
         apb(1'b0, a, 32'h0, rd, err);
         if (rd === exp)
            break;
      end
      chk("latched word", exp, rd);
   endtask
   task automatic load_ref(input logic [13:0] r, input logic [2:0] f);
      load({6'($urandom), f, r, 1'b1}, ADDR_REF, ref_reg(r, f));
   endtask
   task automatic load_main(input logic m, input logic [10:0] n, input logic [6:0] a);
      load({4'($urandom), m, n, a, 1'b0}, ADDR_MAIN, main_reg(m, n, a));
   endtask
   // third gap skips the reload after a new ratio
   task automatic pulse_gap(input int exp);
      int g;
      for (int k = 0; k < 3; k++)
      begin
         g = 0;
         do
         begin
            @(posedge clk);
            g++;
         end
         while (lockOrMonitorPin !== 1'b1 && g < 5000);
         if (g >= 5000)
            hang("monitor pulse");
      end
      chk("monitor gap", 32'(exp), 32'(g));
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [31:0] rd;
      logic [31:0] v;
      logic err;
      logic [13:0] r;
      logic [10:0] n;
      v = $urandom(86378);
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b0, ADDR_REF, 32'h0, rd, err);
      chk("ref reset", ref_reg(RST_REF_DIV, {RST_POL_SEL, RST_MON_SEL, RST_CUR_SEL}), rd);
      apb(1'b0, ADDR_MAIN, 32'h0, rd, err);
      chk("main reset", main_reg(RST_MOD_SEL, RST_PROG_DIV, RST_SWAL_DIV), rd);
      apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
      chk("ctrl reset", {16'h0, RST_ERR_LIMIT, RST_LOCK_TOL}, rd);
      apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
      chk("asleep status", 32'h5, rd & 32'h5);
      chk("asleep lock pin", 32'h1, {31'h0, lockOrMonitorPin});
      // read-write, read-only and unmapped places with random data
      for (int i = 0; i < 3; i++)
      begin
         v = $urandom;
         apb(1'b1, ADDR_CTRL, v, rd, err);
         apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
         chk("ctrl", {16'h0, v[15:0]}, rd);
         apb(1'b1, ADDR_REF, $urandom, rd, err);
         apb(1'b0, ADDR_REF, 32'h0, rd, err);
         chk("ref read only", ref_reg(RST_REF_DIV, {RST_POL_SEL, RST_MON_SEL, RST_CUR_SEL}), rd);
         v = $urandom_range(255, 1);
         apb(i[0], {v[7:0], 4'h0}, $urandom, rd, err);
         chk("unmapped error", 32'h1, {31'h0, err});
         chk("unmapped data", 32'h0, rd);
      end
      // more than 1 us asleep before waking
      repeat (100) @(posedge clk);
      powerSave_n <= 1'b0;
      @(posedge clk);
      powerSave_n <= 1'b1;
      // corner ratios first, then random ones
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk);
         pumpOutputEnable <= 1'($urandom);
         r = (i == 0) ? 14'h3 : (i == 1) ? 14'h3fff : 14'($urandom_range(16383, 3));
         n = (i == 2) ? 11'h3 : (i == 3) ? 11'h7ff : 11'($urandom_range(2047, 3));
         v = (i == 3) ? 127 : $urandom_range((n > 127) ? 127 : n - 1, 0);
         load_ref(r, 3'(i));
         chk("current select", {31'h0, i[0]}, {31'h0, pumpCurrentHigh});
         load_main(i[1], n, v[6:0]);
      end
      @(posedge clk);
      pumpOutputEnable <= 1'b1;
      // power save restarts both dividers on the small ratios
      load_main(1'b1, 11'h3, 7'h2);
      load_ref(14'h5, 3'b110);
      powerSave_n <= 1'b0;
      repeat (8) @(posedge clk);
      powerSave_n <= 1'b1;
      pulse_gap(8 * 5);
      load_ref(14'h5, 3'b010);
      pulse_gap(fp_gap(1'b1, 3, 2));
      load_main(1'b0, 11'h3, 7'h1);
      pulse_gap(fp_gap(1'b0, 3, 1));
      @(posedge clk);
      powerSave_n <= 1'b0;
      repeat (8) @(posedge clk);
      chk("asleep pump", 32'h1, {31'h0, pumpOe_n});
      apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
      chk("asleep flag", 32'h4, rd & 32'h4);
      final_report();
   end
endmodule // spllc_tb_top
